// File: pirq_pkg.sv
/*
 * Package for the pin interrupt block: register offsets, field positions,
 * reset values and sense encodings.
 * Assumes a plain register port with byte offsets, 32-bit data.
 */
package pirq_pkg;
	localparam logic [7:0]  OFF_CTRL      = 8'h00;
	localparam logic [7:0]  OFF_STATUS    = 8'h01;
	localparam logic [7:0]  OFF_NONMASKABLE_CONTROL_REG   = 8'h02;
	localparam logic [7:0]  OFF_NONMASKABLE_FLAG_REG   = 8'h03;
	localparam logic [7:0]  OFF_EVENT_OUT_CONTROL    = 8'h04;
	localparam logic [7:0]  OFF_INTENCLR  = 8'h08;
	localparam logic [7:0]  OFF_IRQ_ENABLE_SET  = 8'h0c;
	localparam logic [7:0]  OFF_IRQ_FLAG_REG   = 8'h10;
	localparam logic [7:0]  OFF_WAKE      = 8'h14;
	localparam logic [7:0]  OFF_CONFIG0   = 8'h18;
	localparam logic [7:0]  OFF_CONFIG1   = 8'h1c;
	localparam int          CTRL_SOFT_RESET_BIT    = 0;
	localparam int          CTRL_ENABLE   = 1;
	localparam int          FILT_BIT      = 3;
	localparam int          CFG_W         = 4;
	localparam int          SYNC_STAGES   = 2;
	localparam logic [31:0] RST_VALUE     = 32'h0000_0000;
	typedef enum logic [2:0] {
		SENSE_NONE = 3'h0,
		SENSE_RISE = 3'h1,
		SENSE_FALL = 3'h2,
		SENSE_BOTH = 3'h3,
		SENSE_HIGH = 3'h4,
		SENSE_LOW  = 3'h5
	} pirq_sense_t;
endpackage : pirq_pkg

// File: pirq_detect.sv
/*
 * One pin detector: optional three-sample majority filter, edge or level
 * sensing, one-cycle hit output on edges, steady hit while a level matches.
 * Assumes pin is already synchronised to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pirq_detect (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Sample enable and config
	input  wire logic       sample_en,
	input  wire logic [2:0] sense,
	input  wire logic       filt_en,
	// Pin and result
	input  wire logic       pin,
	output logic            hit
);
	logic [2:0] samples;
	logic       prev;
	wire        vote  = (samples[0] & samples[1]) | (samples[0] & samples[2])
		| (samples[1] & samples[2]);
	wire        value = filt_en ? vote : pin;
	wire        rise  = value & ~prev;
	wire        fall  = ~value & prev;
	wire        edge_mode = (sense == pirq_pkg::SENSE_RISE) || (sense == pirq_pkg::SENSE_FALL)
		|| (sense == pirq_pkg::SENSE_BOTH);

	always_ff @(posedge clk) begin
		if (rst) begin
			samples <= 3'h0;
			prev    <= 1'b0;
		end else if (sample_en) begin
			samples <= {samples[1:0], pin};
			prev    <= value;
		end
	end

	// Level modes fire every cycle while matching, edges only once
	always_comb begin
		unique case (sense)
			pirq_pkg::SENSE_RISE: hit = sample_en & rise;
			pirq_pkg::SENSE_FALL: hit = sample_en & fall;
			pirq_pkg::SENSE_BOTH: hit = sample_en & (rise | fall);
			pirq_pkg::SENSE_HIGH: hit = value;
			pirq_pkg::SENSE_LOW:  hit = ~value;
			default:              hit = 1'b0;
		endcase
	end
	wire unused_ok = edge_mode;
endmodule : pirq_detect
`default_nettype wire

// File: pirq_top.sv
/*
 * Pin interrupt block: sixteen maskable pins plus one non-maskable pin,
 * edge/level sense, majority filter, flags, requests, events, wake.
 * Assumes one 50 MHz clock; sense sampling runs on a divided enable.
 */
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pirq_top #(
	parameter int NPINS     = 16,
	parameter int SENSE_DIV = 2
) (
	// Clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	// Register port
	input  wire logic [7:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	// Access protection
	input  wire logic        WR_PROTECT,
	input  wire logic        DEBUG_ACCESS,
	// Pins
	input  wire logic [15:0] EXT_IRQ_PIN,
	input  wire logic        NMI_PIN,
	// Outputs
	output logic             IRQ,
	output logic             NMI_IRQ,
	output logic      [15:0] EVENT_OUT,
	output logic             WAKE,
	output logic             SENSE_CLK_REQ,
	// System
	input  wire logic        SLEEPING
);
	initial begin
		if (NPINS != 16 || SENSE_DIV < 1 || SENSE_DIV > 255)
			$error("pirq_top: unsupported parameters");
	end

	// Register state
	logic        enable;
	logic        soft_reset_bit_pend;
	logic        en_pend;
	logic        en_val;
	logic [3:0]  nonmaskable_control_reg;
	logic        nonmaskable_flag_reg;
	logic [15:0] event_out_control;
	logic [15:0] inten;
	logic [15:0] irq_flag_reg;
	logic [15:0] wake_en;
	logic [31:0] cfg0;
	logic [31:0] cfg1;
	logic [7:0]  div_cnt;
	logic        sample_en;

	// Pin synchronisers
	logic [16:0] sync1;
	logic [16:0] sync2;
	always_ff @(posedge SYS_CLK) begin
		sync1 <= {NMI_PIN, EXT_IRQ_PIN};
		sync2 <= sync1;
	end

	// Sense sampling enable, stands in for the separate sense clock
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			div_cnt   <= 8'h00;
			sample_en <= 1'b0;
		end else if (div_cnt == 8'(SENSE_DIV - 1)) begin
			div_cnt   <= 8'h00;
			sample_en <= 1'b1;
		end else begin
			div_cnt   <= div_cnt + 8'h01;
			sample_en <= 1'b0;
		end
	end

	// Writes: protection spares the flag registers and debugger
	wire wr_ok   = WR & (~WR_PROTECT | DEBUG_ACCESS);
	wire wr_ctrl = wr_ok & (ADDR == pirq_pkg::OFF_CTRL);
	wire wr_nmic = wr_ok & (ADDR == pirq_pkg::OFF_NONMASKABLE_CONTROL_REG);
	wire wr_ev   = wr_ok & (ADDR == pirq_pkg::OFF_EVENT_OUT_CONTROL);
	wire wr_iclr = wr_ok & (ADDR == pirq_pkg::OFF_INTENCLR);
	wire wr_iset = wr_ok & (ADDR == pirq_pkg::OFF_IRQ_ENABLE_SET);
	wire wr_wake = wr_ok & (ADDR == pirq_pkg::OFF_WAKE);
	wire wr_cfg0 = wr_ok & (ADDR == pirq_pkg::OFF_CONFIG0);
	wire wr_cfg1 = wr_ok & (ADDR == pirq_pkg::OFF_CONFIG1);
	wire wr_flag = WR & (ADDR == pirq_pkg::OFF_IRQ_FLAG_REG);
	wire wr_nflg = WR & (ADDR == pirq_pkg::OFF_NONMASKABLE_FLAG_REG);
	wire busy    = soft_reset_bit_pend | en_pend;
	wire soft_rst = soft_reset_bit_pend & sample_en;
	wire sync_rst = RST | soft_rst;

	// Control bits take effect on the next sense sample
	always_ff @(posedge SYS_CLK) begin
		if (sync_rst) begin
			soft_reset_bit_pend <= 1'b0;
			en_pend    <= 1'b0;
			en_val     <= 1'b0;
			enable     <= 1'b0;
		end else if (wr_ctrl && WDATA[pirq_pkg::CTRL_SOFT_RESET_BIT]) begin
			soft_reset_bit_pend <= 1'b1;
		end else if (wr_ctrl) begin
			en_pend <= 1'b1;
			en_val  <= WDATA[pirq_pkg::CTRL_ENABLE];
		end else if (en_pend && sample_en) begin
			en_pend <= 1'b0;
			enable  <= en_val;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (sync_rst) begin
			nonmaskable_control_reg <= 4'h0;
			event_out_control  <= 16'h0000;
			inten   <= 16'h0000;
			wake_en <= 16'h0000;
			cfg0    <= pirq_pkg::RST_VALUE;
			cfg1    <= pirq_pkg::RST_VALUE;
		end else begin
			if (wr_nmic)
				nonmaskable_control_reg <= WDATA[3:0];
			if (wr_ev)
				event_out_control <= WDATA[15:0];
			if (wr_iset)
				inten <= inten | WDATA[15:0];
			else if (wr_iclr)
				inten <= inten & ~WDATA[15:0];
			if (wr_wake)
				wake_en <= WDATA[15:0];
			if (wr_cfg0)
				cfg0 <= WDATA;
			if (wr_cfg1)
				cfg1 <= WDATA;
		end
	end

	// Detectors, pins 0..7 in config0, 8..15 in config1
	// Padding keeps the unused pin-16 slice in range; that slot uses nonmaskable_control_reg
	wire [255:0] cfg_all = {192'h0, cfg1, cfg0};
	logic [16:0] hit;
	logic [16:0] needs_clk;
	genvar g;
	generate
		for (g = 0; g < 17; g++) begin : g_det
			wire [2:0] sns = (g == 16) ? nonmaskable_control_reg[2:0] : cfg_all[g*4 +: 3];
			wire       flt = (g == 16) ? nonmaskable_control_reg[pirq_pkg::FILT_BIT]
				: cfg_all[g*4 + pirq_pkg::FILT_BIT];
			assign needs_clk[g] = flt | (sns == pirq_pkg::SENSE_RISE)
				| (sns == pirq_pkg::SENSE_FALL) | (sns == pirq_pkg::SENSE_BOTH);
			pirq_detect u_det (
				.clk       (SYS_CLK),
				.rst       (sync_rst),
				.sample_en (sample_en),
				.sense     (sns),
				.filt_en   (flt),
				.pin       (sync2[g]),
				.hit       (hit[g])
			);
		end
	endgenerate

	// Flags: a hit in the clear cycle wins, debug halt has no effect
	wire [15:0] pin_hit = hit[15:0] & {16{enable}};
	always_ff @(posedge SYS_CLK) begin
		if (sync_rst) begin
			irq_flag_reg <= 16'h0000;
			nonmaskable_flag_reg <= 1'b0;
		end else begin
			irq_flag_reg <= (irq_flag_reg & ~(wr_flag ? WDATA[15:0] : 16'h0000)) | pin_hit;
			nonmaskable_flag_reg <= (nonmaskable_flag_reg & ~(wr_nflg & WDATA[0])) | hit[16];
		end
	end

	// Registered outputs
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			IRQ           <= 1'b0;
			NMI_IRQ       <= 1'b0;
			EVENT_OUT     <= 16'h0000;
			WAKE          <= 1'b0;
			SENSE_CLK_REQ <= 1'b0;
		end else begin
			IRQ           <= |(irq_flag_reg & inten);
			NMI_IRQ       <= nonmaskable_flag_reg;
			EVENT_OUT     <= pin_hit & event_out_control;
			WAKE          <= SLEEPING & |(pin_hit & wake_en & inten);
			SENSE_CLK_REQ <= (|needs_clk[15:0] & enable) | needs_clk[16];
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	logic [31:0] rd_mux;
	always_comb begin
		unique case (ADDR)
			pirq_pkg::OFF_CTRL:     rd_mux = {30'h0, enable, 1'b0};
			pirq_pkg::OFF_STATUS:   rd_mux = {24'h0, busy, 7'h0};
			pirq_pkg::OFF_NONMASKABLE_CONTROL_REG:  rd_mux = {28'h0, nonmaskable_control_reg};
			pirq_pkg::OFF_NONMASKABLE_FLAG_REG:  rd_mux = {31'h0, nonmaskable_flag_reg};
			pirq_pkg::OFF_EVENT_OUT_CONTROL:   rd_mux = {16'h0, event_out_control};
			pirq_pkg::OFF_INTENCLR: rd_mux = {16'h0, inten};
			pirq_pkg::OFF_IRQ_ENABLE_SET: rd_mux = {16'h0, inten};
			pirq_pkg::OFF_IRQ_FLAG_REG:  rd_mux = {16'h0, irq_flag_reg};
			pirq_pkg::OFF_WAKE:     rd_mux = {16'h0, wake_en};
			pirq_pkg::OFF_CONFIG0:  rd_mux = cfg0;
			pirq_pkg::OFF_CONFIG1:  rd_mux = cfg1;
			default:                rd_mux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge SYS_CLK) begin
		if (RST)
			RDATA <= 32'h0000_0000;
		else
			RDATA <= RD ? rd_mux : 32'h0000_0000;
	end
endmodule : pirq_top
`default_nettype wire

// File: pirq_top_checker.sv
/* Port checker for pirq_top.
   Bound onto every pirq_top instance; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module pirq_checker #(
	parameter int SENSE_DIV = 2
) (
	// Inputs of the block
	input wire logic        SYS_CLK,
	input wire logic        RST,
	input wire logic [7:0]  ADDR,
	input wire logic [31:0] WDATA,
	input wire logic        WR,
	input wire logic        WR_PROTECT,
	input wire logic        DEBUG_ACCESS,
	input wire logic        SLEEPING,
	// Outputs of the block
	input wire logic        IRQ,
	input wire logic        NMI_IRQ,
	input wire logic [15:0] EVENT_OUT,
	input wire logic        WAKE,
	input wire logic        SENSE_CLK_REQ
);
	logic        wr_ok;
	logic [3:0]  wr_age;
	logic [15:0] ev_mask;
	logic        en_seen, ie_seen, cfg_seen, nmi_seen;
	function automatic logic at(input logic [7:0] a);
		return wr_ok && ADDR == a;
	endfunction : at
	// Sticky since reset; soft reset only makes outputs quieter
	assign wr_ok = WR && (!WR_PROTECT || DEBUG_ACCESS);
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			wr_age   <= 4'hf;
			ev_mask  <= 16'h0;
			en_seen  <= 1'b0;
			ie_seen  <= 1'b0;
			cfg_seen <= 1'b0;
			nmi_seen <= 1'b0;
		end else begin
			wr_age   <= WR ? 4'h0 : wr_age + {3'h0, wr_age != 4'hf};
			ev_mask  <= ev_mask | (at(pirq_pkg::OFF_EVENT_OUT_CONTROL) ? WDATA[15:0] : 16'h0);
			en_seen  <= en_seen | (at(pirq_pkg::OFF_CTRL) && WDATA[1]);
			ie_seen  <= ie_seen | (at(pirq_pkg::OFF_IRQ_ENABLE_SET) && WDATA[15:0] != 16'h0);
			cfg_seen <= cfg_seen | at(pirq_pkg::OFF_CONFIG0) | at(pirq_pkg::OFF_CONFIG1)
				| at(pirq_pkg::OFF_NONMASKABLE_CONTROL_REG);
			nmi_seen <= nmi_seen | (at(pirq_pkg::OFF_NONMASKABLE_CONTROL_REG) && WDATA[2:0] != 3'h0);
		end
	end
	default clocking dc @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);
	a_reset_quiet: assert property (disable iff (1'b0) $past(RST) |-> !IRQ && !NMI_IRQ
		&& !WAKE && !SENSE_CLK_REQ && EVENT_OUT == 16'h0) else $error("outputs busy after reset");
	a_irq_holds: assert property ($fell(IRQ) |-> wr_age <= SENSE_DIV + 5)
		else $error("IRQ dropped with no write");
	a_nmi_holds: assert property ($fell(NMI_IRQ) |-> wr_age <= SENSE_DIV + 5)
		else $error("NMI_IRQ dropped with no write");
	a_wake_sleep: assert property (WAKE |-> $past(SLEEPING) && ie_seen)
		else $error("wake while awake or masked");
	a_evt_enable: assert property (EVENT_OUT != 16'h0 |-> en_seen)
		else $error("event from a block never enabled");
	a_evt_mask: assert property ((EVENT_OUT & ~ev_mask) == 16'h0)
		else $error("event on a pin without event enable");
	a_clk_request: assert property (SENSE_CLK_REQ |-> cfg_seen)
		else $error("sense clock asked with no config");
	a_nmi_cause: assert property ($rose(NMI_IRQ) |-> nmi_seen)
		else $error("NMI_IRQ with sense none");
	a_irq_cause: assert property ($rose(IRQ) |-> ie_seen)
		else $error("IRQ with no enable");
	c_irq: cover property ($rose(IRQ));
	c_nmi: cover property ($rose(NMI_IRQ));
	c_wake: cover property (WAKE);
	c_event: cover property (EVENT_OUT != 16'h0);
endmodule : pirq_checker
bind pirq_top pirq_checker #(.SENSE_DIV(SENSE_DIV)) u_pirq_checker (
	.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
	.WR_PROTECT(WR_PROTECT), .DEBUG_ACCESS(DEBUG_ACCESS), .SLEEPING(SLEEPING),
	.IRQ(IRQ), .NMI_IRQ(NMI_IRQ), .EVENT_OUT(EVENT_OUT), .WAKE(WAKE),
	.SENSE_CLK_REQ(SENSE_CLK_REQ));
`default_nettype wire

// File: pirq_sink.sv
/* Event router stand-in: counts event pulses.
   Assumes events are one-cycle pulses on the system clock. */
`timescale 1ns/1ps
`default_nettype none
module pirq_sink (
	// Event lines in
	input wire logic        clk,
	input wire logic [15:0] event_out
);
	int n_evt = 0;
	always_ff @(posedge clk) begin
		n_evt <= n_evt + $countones(event_out);
	end
endmodule : pirq_sink
`default_nettype wire

// File: tb_pirq_top.sv
/* Self-checking bench for pirq_top.
   Sense table on pin 0, then protection, NMI, wake and soft reset. */
`timescale 1ns/1ps
`default_nettype none
module tb_pirq_top;
	typedef struct packed {logic [3:0] cfg; logic pa; logic pb; logic hit;} pirq_row_t;
	// Before-clear pin level, after-clear pin level, flag expected
	localparam pirq_row_t ROWS [13] = '{'{4'h0,0,1,0}, '{4'h1,0,1,1}, '{4'h1,1,0,0},
		'{4'h1,1,1,0}, '{4'h2,1,0,1}, '{4'h2,0,1,0}, '{4'h3,1,0,1}, '{4'h4,0,1,1},
		'{4'h5,0,0,1}, '{4'h6,0,1,0}, '{4'h7,1,0,0}, '{4'h9,0,1,1}, '{4'hc,0,1,1}};
	logic SYS_CLK, RST = 1, WR = 0, RD = 0, WR_PROTECT = 0, DEBUG_ACCESS = 0;
	logic NMI_PIN = 0, SLEEPING = 0, IRQ, NMI_IRQ, WAKE, SENSE_CLK_REQ, seen;
	logic [7:0]  ADDR = 8'h0;
	logic [31:0] WDATA = 32'h0, RDATA, d;
	logic [15:0] EXT_IRQ_PIN = 16'h0, EVENT_OUT;
	int n_errors = 0, comparisons = 0, cyc = 0, n0;
	pirq_top #(.SENSE_DIV(2)) u_pirq_top (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .WR_PROTECT(WR_PROTECT),
		.DEBUG_ACCESS(DEBUG_ACCESS), .EXT_IRQ_PIN(EXT_IRQ_PIN), .NMI_PIN(NMI_PIN),
		.IRQ(IRQ), .NMI_IRQ(NMI_IRQ), .EVENT_OUT(EVENT_OUT), .WAKE(WAKE),
		.SENSE_CLK_REQ(SENSE_CLK_REQ), .SLEEPING(SLEEPING));
	pirq_sink u_pirq_sink (.clk(SYS_CLK), .event_out(EVENT_OUT));
	task automatic idle(input int n);
		repeat (n) @(posedge SYS_CLK);
	endtask : idle
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge SYS_CLK);
		ADDR <= a;
		WDATA <= v;
		WR <= 1'b1;
		@(posedge SYS_CLK);
		WR <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge SYS_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge SYS_CLK);
		RD <= 1'b0;
		#1 v = RDATA;
	endtask : rd
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wake_seen(output logic w);
		w = 1'b0;
		repeat (16) begin
			@(posedge SYS_CLK);
			w |= WAKE;
		end
	endtask : wake_seen
	task automatic stop_test();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	initial begin
		SYS_CLK = 1'b0;
		forever #10 SYS_CLK = ~SYS_CLK;
	end
	// Whole run is about 780 cycles
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 6000) begin
			n_errors++;
			stop_test();
		end
	end
	initial begin
		idle(12);
		RST <= 1'b0;
		rd(pirq_pkg::OFF_EVENT_OUT_CONTROL, d);
		chk(d, 32'h0);
		chk(SENSE_CLK_REQ, 1'b0);
		wr(pirq_pkg::OFF_IRQ_ENABLE_SET, 32'h1);
		wr(pirq_pkg::OFF_EVENT_OUT_CONTROL, 32'h1);
		wr(pirq_pkg::OFF_CTRL, 32'h2);
		foreach (ROWS[i]) begin
			EXT_IRQ_PIN[0] <= ROWS[i].pa;
			wr(pirq_pkg::OFF_CONFIG0, {28'h0, ROWS[i].cfg});
			idle(20);
			wr(pirq_pkg::OFF_IRQ_FLAG_REG, 32'hffff);
			n0 = u_pirq_sink.n_evt;
			EXT_IRQ_PIN[0] <= ROWS[i].pb;
			idle(24);
			chk(IRQ, ROWS[i].hit);
			chk(u_pirq_sink.n_evt != n0, ROWS[i].hit);
			rd(pirq_pkg::OFF_IRQ_FLAG_REG, d);
			chk(d, {31'h0, ROWS[i].hit});
		end
		chk(SENSE_CLK_REQ, 1'b1);
		EXT_IRQ_PIN[0] <= 1'b0;
		WR_PROTECT <= 1'b1;
		idle(20);
		wr(pirq_pkg::OFF_EVENT_OUT_CONTROL, 32'h2);
		wr(pirq_pkg::OFF_IRQ_FLAG_REG, 32'hffff);
		rd(pirq_pkg::OFF_EVENT_OUT_CONTROL, d);
		chk(d, 32'h1);
		rd(pirq_pkg::OFF_IRQ_FLAG_REG, d);
		chk(d, 32'h0);
		DEBUG_ACCESS <= 1'b1;
		wr(pirq_pkg::OFF_EVENT_OUT_CONTROL, 32'h3);
		rd(pirq_pkg::OFF_EVENT_OUT_CONTROL, d);
		chk(d, 32'h3);
		WR_PROTECT <= 1'b0;
		DEBUG_ACCESS <= 1'b0;
		wr(pirq_pkg::OFF_NONMASKABLE_CONTROL_REG, 32'h4);
		NMI_PIN <= 1'b1;
		idle(8);
		chk(NMI_IRQ, 1'b1);
		NMI_PIN <= 1'b0;
		idle(4);
		wr(pirq_pkg::OFF_NONMASKABLE_FLAG_REG, 32'h1);
		idle(3);
		chk(NMI_IRQ, 1'b0);
		SLEEPING <= 1'b1;
		wr(pirq_pkg::OFF_CONFIG0, 32'h40);
		wr(pirq_pkg::OFF_IRQ_ENABLE_SET, 32'h2);
		wr(pirq_pkg::OFF_WAKE, 32'h2);
		EXT_IRQ_PIN[1] <= 1'b1;
		wake_seen(seen);
		chk(seen, 1'b1);
		wr(pirq_pkg::OFF_WAKE, 32'h0);
		idle(3);
		wake_seen(seen);
		chk(seen, 1'b0);
		SLEEPING <= 1'b0;
		wr(pirq_pkg::OFF_CTRL, 32'h1);
		idle(8);
		rd(pirq_pkg::OFF_EVENT_OUT_CONTROL, d);
		chk(d, 32'h0);
		rd(pirq_pkg::OFF_CTRL, d);
		chk(d, 32'h0);
		chk(SENSE_CLK_REQ, 1'b0);
		stop_test();
	end
endmodule : tb_pirq_top
`default_nettype wire
